// [rtl/uls_top.sv]
/*
 uls_top: one uart channel with format, modem-output and line-status logic,
 a wishbone classic slave, baud divider, transmitter and receiver.
 assumes inputs synchronous to clk and a master that holds its request.
*/
// Chosen here: register access over Wishbone and the placing of the registers.
// What this block does
// - parity enable adds a parity bit on transmit and checks it on receive.
// - unforced parity is odd when select is 0, even when 1, both directions.
// - forced parity bit is 1 when select is 0, 0 when select is 1.
// - outside loopback, break bit holds the serial output low until software clears it.
// - divisor access bit steers shared offsets to the divisor latches.
// - outside loopback, dtr bit 1 drives the active-low dtr pin low, 0 drives it high.
// - rts bit drives active-low rts pin unless loopback or auto flow control owns it.
// - in loopback, control bit 2 drives internal output one inverted.
// - interrupt output floats only with select pin low and enable bit low.
// - in loopback, interrupt-enable bit drives internal output two inverted.
// - loopback bit 1 loops the channel internally, 0 is normal operation.
// - xon-any resumes a halted transmitter on any received character except xoff.
// - infrared bit routes serial data through the encoder, idle output low.
// - prescaler bit divides the input clock by four before the divider.
// - overrun interrupts at once, character errors when they reach holding.
// - data ready is 1 while a received character waits.
// - a character arriving while full sets overrun and is dropped.
// - parity error flag belongs to the character now in holding.
// - framing error flag belongs to the character now in holding.
// - one break character per low line, held until the line goes high.
// - holding-empty sets on move to shifter, clears on host write.
// - reading line status clears a pending line status interrupt.
// - two low format bits give 5, 6, 7 or 8 data bits.
`timescale 1ns/1ps
`default_nettype none
module uls_top (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic ack_o,
    output logic [31:0] dat_o,
    input wire logic rxSerial,
    output logic txSerial,
    input wire logic irRx,
    output logic irTx,
    output logic dtrN,
    output logic rtsN,
    input wire logic interruptOutputSelectPin,
    input wire logic busMode68,
    output logic intOut,
    output logic intOe,
    output logic internalOutputOneN,
    output logic internalOutputTwoN
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    logic wbAck_q;
    logic [31:0] rdData_q;
    logic [7:0] lcr_q, mcr_q, ier_q, efr_q, xon_q, xoff_q;
    logic [15:0] div_q;
    logic [2:0] regIdx;
    logic mapped, req, doWrite, doRead, thrWrite, rhrRead, lsrRead;
    logic [7:0] rdByte, lsrVal;
    logic enh, loop, irMode, pen, swFlow;
    logic [3:0] charLen;
    logic [7:0] dataMask;

    assign req = cyc_i & stb_i;
    assign regIdx = adr_i[4:2];
    assign mapped = (adr_i[7:5] == 3'h0);
    // effects land on the edge where the master sees ack
    assign doWrite = req & wbAck_q & we_i & sel_i[0] & mapped;
    assign doRead = req & wbAck_q & ~we_i & mapped;
    assign thrWrite = doWrite & (regIdx == uls_pkg::OFS_DATA)
        & ~lcr_q[uls_pkg::LCR_DLAB];
    assign rhrRead = doRead & (regIdx == uls_pkg::OFS_DATA)
        & ~lcr_q[uls_pkg::LCR_DLAB];
    assign lsrRead = doRead & (regIdx == uls_pkg::OFS_LSR);
    assign ack_o = wbAck_q;
    assign dat_o = rdData_q;

    assign enh = efr_q[uls_pkg::EFR_ENH];
    assign loop = mcr_q[uls_pkg::MCR_LOOP];
    assign irMode = enh & mcr_q[uls_pkg::MCR_IR];
    assign pen = lcr_q[uls_pkg::LCR_PEN];
    assign swFlow = (efr_q[1:0] != 2'h0);
    assign charLen = {2'h0, lcr_q[1:0]} + uls_pkg::LEN_BASE;
    assign dataMask = 8'hff >> (4'h8 - charLen);

    // odd when select is 0, forced level is the inverse of select
    function automatic logic parityOf(input logic [7:0] d);
        if (lcr_q[uls_pkg::LCR_FORCE]) begin
            return ~lcr_q[uls_pkg::LCR_EVEN];
        end
        return lcr_q[uls_pkg::LCR_EVEN] ? ^d : ~^d;
    endfunction : parityOf

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wbAck_q <= 1'b0;
        end else if (ce) begin
            wbAck_q <= req & ~wbAck_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            lcr_q <= uls_pkg::LCR_RST;
            mcr_q <= uls_pkg::MCR_RST;
            ier_q <= uls_pkg::IER_RST;
            efr_q <= uls_pkg::EFR_RST;
            xon_q <= uls_pkg::XON_RST;
            xoff_q <= uls_pkg::XOFF_RST;
            div_q <= uls_pkg::DIV_RST;
        end else if (ce && doWrite) begin
            case (regIdx)
                uls_pkg::OFS_DATA: begin
                    if (lcr_q[uls_pkg::LCR_DLAB]) begin
                        div_q[7:0] <= dat_i[7:0];
                    end
                end
                uls_pkg::OFS_IER: begin
                    if (lcr_q[uls_pkg::LCR_DLAB]) begin
                        div_q[15:8] <= dat_i[7:0];
                    end else begin
                        ier_q <= dat_i[7:0];
                    end
                end
                uls_pkg::OFS_EFR: efr_q <= dat_i[7:0];
                uls_pkg::OFS_LCR: lcr_q <= dat_i[7:0];
                uls_pkg::OFS_MCR: mcr_q <= dat_i[7:0];
                uls_pkg::OFS_XON: xon_q <= dat_i[7:0];
                uls_pkg::OFS_XOFF: xoff_q <= dat_i[7:0];
                default: ;
            endcase
        end
    end

    // baud tick at sixteen times the bit rate
    logic [1:0] prescCnt_q;
    logic [15:0] divCnt_q;
    logic prescTick, tick16;
    logic [15:0] divEff;

    assign prescTick = (enh & mcr_q[uls_pkg::MCR_PRESC])
        ? (prescCnt_q == uls_pkg::PRESC_LAST) : 1'b1;
    assign divEff = (div_q == 16'h0000) ? 16'h0001 : div_q;
    // >= so a smaller divisor written mid-count cannot stall the counter
    assign tick16 = prescTick & (divCnt_q >= divEff - 16'h0001);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            prescCnt_q <= 2'h0;
            divCnt_q <= 16'h0000;
        end else if (ce) begin
            prescCnt_q <= prescCnt_q + 2'h1;
            if (prescTick) begin
                divCnt_q <= tick16 ? 16'h0000 : divCnt_q + 16'h0001;
            end
        end
    end

    // transmitter: holding register, then a start/data/parity shifter
    logic [7:0] txHold_q;
    logic thrFull_q, txBusy_q, txStop_q, txHalt_q;
    logic [9:0] txShift_q;
    logic [3:0] txBitsLeft_q;
    logic [5:0] txTick_q;
    logic txLoad, txLine, txBit, txParBit;
    logic [8:0] txBody;
    logic [5:0] stopTicks;

    assign txLoad = thrFull_q & ~txBusy_q & ~txHalt_q;
    assign txParBit = pen & parityOf(txHold_q & dataMask);
    assign txBody = {1'b0, txHold_q & dataMask}
        | (9'(txParBit) << charLen);
    assign stopTicks = ~lcr_q[uls_pkg::LCR_STOP] ? uls_pkg::STOP1_TICKS
        : (lcr_q[1:0] == 2'h0) ? uls_pkg::STOP15_TICKS
        : uls_pkg::STOP2_TICKS;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            txHold_q <= 8'h00;
            thrFull_q <= 1'b0;
        end else if (ce) begin
            if (thrWrite) begin
                txHold_q <= dat_i[7:0];
                thrFull_q <= 1'b1;
            end else if (txLoad) begin
                thrFull_q <= 1'b0;
            end
        end
    end

    // data length and parity are sampled at load; the stop length is read live, so a mid-frame change alters only the stop period
    always_ff @(posedge clk) begin
        if (!resetn) begin
            txBusy_q <= 1'b0;
            txStop_q <= 1'b0;
            txShift_q <= 10'h3ff;
            txBitsLeft_q <= 4'h0;
            txTick_q <= 6'h00;
        end else if (ce) begin
            if (txLoad) begin
                txShift_q <= {txBody, 1'b0};
                txBitsLeft_q <= charLen + {3'h0, pen} + 4'h1;
                txTick_q <= 6'h00;
                txBusy_q <= 1'b1;
                txStop_q <= 1'b0;
            end else if (txBusy_q && tick16) begin
                txTick_q <= txTick_q + 6'h01;
                if (!txStop_q && txTick_q == uls_pkg::BIT_TICKS - 6'h01) begin
                    txShift_q <= {1'b1, txShift_q[9:1]};
                    txBitsLeft_q <= txBitsLeft_q - 4'h1;
                    txTick_q <= 6'h00;
                    txStop_q <= (txBitsLeft_q == 4'h1);
                end else if (txStop_q && txTick_q == stopTicks - 6'h01) begin
                    txBusy_q <= 1'b0;
                    txTick_q <= 6'h00;
                end
            end
        end
    end

    assign txLine = (txBusy_q & ~txStop_q) ? txShift_q[0] : 1'b1;
    assign txBit = lcr_q[uls_pkg::LCR_BRK] ? 1'b0 : txLine;
    // looped data stays internal, the pin rests at mark
    assign txSerial = loop ? 1'b1 : txBit;
    assign irTx = irMode & ~loop & ~txBit
        & (txTick_q < uls_pkg::IR_PULSE_TICKS);

    // receiver input selection and infrared pulse stretch
    logic [5:0] irHold_q;
    logic rxIn;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            irHold_q <= 6'h00;
        end else if (ce) begin
            if (irRx) begin
                irHold_q <= uls_pkg::BIT_TICKS;
            end else if (tick16 && irHold_q != 6'h00) begin
                irHold_q <= irHold_q - 6'h01;
            end
        end
    end

    assign rxIn = loop ? txBit
        : irMode ? (irHold_q == 6'h00) : rxSerial;

    uls_pkg::uls_rx_e rxState_q;
    logic [5:0] rxTick_q;
    logic [3:0] rxCnt_q;
    logic [8:0] rxShift_q;
    logic rxDone, rxPe, rxFe, rxBi, isXon, isXoff, isFlow;
    logic storeEv, overrunEv, errStore;
    logic [7:0] rxData;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rxState_q <= uls_pkg::RX_IDLE;
            rxTick_q <= 6'h00;
            rxCnt_q <= 4'h0;
            rxShift_q <= 9'h000;
        end else if (ce && tick16) begin
            rxTick_q <= rxTick_q + 6'h01;
            case (rxState_q)
                uls_pkg::RX_IDLE: begin
                    rxTick_q <= 6'h00;
                    if (!rxIn) begin
                        rxState_q <= uls_pkg::RX_START;
                    end
                end
                uls_pkg::RX_START: begin
                    if (rxTick_q == uls_pkg::HALF_TICKS - 6'h01) begin
                        rxTick_q <= 6'h00;
                        rxCnt_q <= 4'h0;
                        rxShift_q <= 9'h000;
                        rxState_q <= rxIn ? uls_pkg::RX_IDLE
                            : uls_pkg::RX_BITS;
                    end
                end
                uls_pkg::RX_BITS: begin
                    if (rxTick_q == uls_pkg::BIT_TICKS - 6'h01) begin
                        rxTick_q <= 6'h00;
                        if (rxCnt_q != charLen + {3'h0, pen}) begin
                            rxShift_q[rxCnt_q] <= rxIn;
                            rxCnt_q <= rxCnt_q + 4'h1;
                        end else begin
                            rxState_q <= rxBi ? uls_pkg::RX_WAITHI
                                : uls_pkg::RX_IDLE;
                        end
                    end
                end
                uls_pkg::RX_WAITHI: begin
                    if (rxIn) begin
                        rxState_q <= uls_pkg::RX_IDLE;
                    end
                end
                default: rxState_q <= uls_pkg::RX_IDLE;
            endcase
        end
    end

    assign rxDone = ce & tick16 & (rxState_q == uls_pkg::RX_BITS)
        & (rxTick_q == uls_pkg::BIT_TICKS - 6'h01)
        & (rxCnt_q == charLen + {3'h0, pen});
    assign rxData = rxShift_q[7:0] & dataMask;
    assign rxPe = pen & (rxShift_q[charLen] != parityOf(rxData));
    assign rxFe = ~rxIn;
    assign rxBi = ~rxIn & (rxShift_q == 9'h000);
    assign isXon = swFlow & ~rxBi & (rxData == xon_q);
    assign isXoff = swFlow & ~rxBi & (rxData == xoff_q);
    assign isFlow = isXon | isXoff;

    logic [7:0] rxHold_q;
    logic rxValid_q, rxPe_q, rxFe_q, rxBi_q, overrun_q, lsIntPend_q;

    assign overrunEv = rxDone & ~isFlow & rxValid_q & ~rhrRead;
    assign storeEv = rxDone & ~isFlow & ~overrunEv;
    assign errStore = storeEv & (rxPe | rxFe | rxBi);

    // a full holding register is kept intact, the new byte is lost
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rxHold_q <= 8'h00;
            rxValid_q <= 1'b0;
            rxPe_q <= 1'b0;
            rxFe_q <= 1'b0;
            rxBi_q <= 1'b0;
        end else if (ce) begin
            if (storeEv) begin
                rxHold_q <= rxData;
                rxValid_q <= 1'b1;
                rxPe_q <= rxPe;
                rxFe_q <= rxFe;
                rxBi_q <= rxBi;
            end else if (rhrRead) begin
                rxValid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            overrun_q <= 1'b0;
            lsIntPend_q <= 1'b0;
        end else if (ce) begin
            if (overrunEv) begin
                overrun_q <= 1'b1;
            end else if (lsrRead) begin
                overrun_q <= 1'b0;
            end
            if (ier_q[uls_pkg::IER_LSI] && (overrunEv || errStore)) begin
                lsIntPend_q <= 1'b1;
            end else if (lsrRead) begin
                lsIntPend_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            txHalt_q <= 1'b0;
        end else if (ce && rxDone) begin
            if (isXoff) begin
                txHalt_q <= 1'b1;
            end else if (isXon || (enh && mcr_q[uls_pkg::MCR_XANY])) begin
                txHalt_q <= 1'b0;
            end
        end
    end

    assign lsrVal = {2'h0, ~thrFull_q, rxBi_q & rxValid_q,
        rxFe_q & rxValid_q, rxPe_q & rxValid_q, overrun_q, rxValid_q};

    always_comb begin
        rdByte = 8'h00;
        case (regIdx)
            uls_pkg::OFS_DATA: rdByte = lcr_q[uls_pkg::LCR_DLAB]
                ? div_q[7:0] : rxHold_q;
            uls_pkg::OFS_IER: rdByte = lcr_q[uls_pkg::LCR_DLAB]
                ? div_q[15:8] : ier_q;
            uls_pkg::OFS_EFR: rdByte = efr_q;
            uls_pkg::OFS_LCR: rdByte = lcr_q;
            uls_pkg::OFS_MCR: rdByte = mcr_q;
            uls_pkg::OFS_LSR: rdByte = lsrVal;
            uls_pkg::OFS_XON: rdByte = xon_q;
            uls_pkg::OFS_XOFF: rdByte = xoff_q;
            default: rdByte = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdData_q <= 32'h0000_0000;
        end else if (ce && req && !wbAck_q) begin
            rdData_q <= {24'h00_0000, mapped ? rdByte : 8'h00};
        end
    end

    // modem pins go inactive in loopback; the looped levels stay inside
    assign dtrN = loop | ~mcr_q[uls_pkg::MCR_DTR];
    assign rtsN = loop ? 1'b1 : efr_q[uls_pkg::EFR_ARTS] ? rxValid_q
        : ~mcr_q[uls_pkg::MCR_RTS];
    assign internalOutputOneN = loop ? ~mcr_q[uls_pkg::MCR_OP1] : 1'b1;
    assign internalOutputTwoN = loop ? ~mcr_q[uls_pkg::MCR_INTEN]
        : 1'b1;
    assign intOut = lsIntPend_q;
    // is the board's: select is assumed low whenever 68 mode is used
    assign intOe = busMode68 | interruptOutputSelectPin
        | mcr_q[uls_pkg::MCR_INTEN];

    property p_brk;
        lcr_q[uls_pkg::LCR_BRK] && !loop |-> !txSerial;
    endproperty
    a_brk: assert property (p_brk) else $error("break not driving low");

    property p_dtr;
        !loop |-> dtrN == !mcr_q[uls_pkg::MCR_DTR];
    endproperty
    a_dtr: assert property (p_dtr) else $error("dtr pin wrong");

    property p_rts;
        !loop && !efr_q[uls_pkg::EFR_ARTS] |-> rtsN == !mcr_q[1];
    endproperty
    a_rts: assert property (p_rts) else $error("rts pin wrong");

    property p_intoe;
        intOe == !(!busMode68 && !interruptOutputSelectPin
            && !mcr_q[uls_pkg::MCR_INTEN]);
    endproperty
    a_intoe: assert property (p_intoe) else $error("int enable wrong");

    property p_op2;
        loop |-> internalOutputTwoN == !mcr_q[uls_pkg::MCR_INTEN];
    endproperty
    a_op2: assert property (p_op2) else $error("op2 level wrong");

    property p_ready;
        storeEv |=> rxValid_q && lsrVal[0] && rxHold_q == $past(rxData);
    endproperty
    a_ready: assert property (p_ready) else $error("no data ready");

    property p_ovr;
        overrunEv |=> overrun_q && $stable(rxHold_q) && rxValid_q;
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrun mishandled");

    property p_thre;
        ce && thrWrite |=> !lsrVal[5] [*1] ##0 thrFull_q;
    endproperty
    a_thre: assert property (p_thre) else $error("thr empty stuck");

    property p_lsclr;
        ce && lsrRead && !overrunEv && !errStore |=> !intOut;
    endproperty
    a_lsclr: assert property (p_lsclr) else $error("ls int stuck");

    property p_ack;
        ce && req && !wbAck_q |=> ack_o ##1 (!ce || !ack_o);
    endproperty
    a_ack: assert property (p_ack) else $error("ack timing wrong");
endmodule : uls_top
`default_nettype wire

// [include/uls_pkg.sv]
/*
 uls_pkg: register map, field positions, reset values, timing counts and
 receiver states of the uart line and modem control/status block.
 assumes a 32-bit classic wishbone slave with one register per word.
*/
`default_nettype none
package uls_pkg;
    // word index within the map, byte address is four times the index
    localparam logic [2:0] OFS_DATA = 3'h0;
    localparam logic [2:0] OFS_IER = 3'h1;
    localparam logic [2:0] OFS_EFR = 3'h2;
    localparam logic [2:0] OFS_LCR = 3'h3;
    localparam logic [2:0] OFS_MCR = 3'h4;
    localparam logic [2:0] OFS_LSR = 3'h5;
    localparam logic [2:0] OFS_XON = 3'h6;
    localparam logic [2:0] OFS_XOFF = 3'h7;

    localparam logic [7:0] LCR_RST = 8'h00;
    localparam logic [7:0] MCR_RST = 8'h00;
    localparam logic [7:0] IER_RST = 8'h00;
    localparam logic [7:0] EFR_RST = 8'h00;
    localparam logic [7:0] XON_RST = 8'h00;
    localparam logic [7:0] XOFF_RST = 8'h00;
    localparam logic [15:0] DIV_RST = 16'h0001;

    localparam int LCR_STOP = 2;
    localparam int LCR_PEN = 3;
    localparam int LCR_EVEN = 4;
    localparam int LCR_FORCE = 5;
    localparam int LCR_BRK = 6;
    localparam int LCR_DLAB = 7;
    localparam int MCR_DTR = 0;
    localparam int MCR_RTS = 1;
    localparam int MCR_OP1 = 2;
    localparam int MCR_INTEN = 3;
    localparam int MCR_LOOP = 4;
    localparam int MCR_XANY = 5;
    localparam int MCR_IR = 6;
    localparam int MCR_PRESC = 7;
    localparam int EFR_ENH = 4;
    localparam int EFR_ARTS = 6;
    localparam int IER_LSI = 2;

    localparam logic [3:0] LEN_BASE = 4'h5;
    localparam logic [1:0] PRESC_LAST = 2'h3;
    localparam logic [5:0] BIT_TICKS = 6'h10;
    localparam logic [5:0] HALF_TICKS = 6'h08;
    localparam logic [5:0] STOP1_TICKS = 6'h10;
    localparam logic [5:0] STOP15_TICKS = 6'h18;
    localparam logic [5:0] STOP2_TICKS = 6'h20;
    localparam logic [5:0] IR_PULSE_TICKS = 6'h03;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_BITS = 2'b10,
        RX_WAITHI = 2'b11
    } uls_rx_e;
endpackage : uls_pkg
`default_nettype wire

// [sim/uls_line_model.sv]
/*
 uls_line_model: remote serial end that sends and captures frames.
 assumes divisor 1, no prescale, so one bit lasts 16 clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module uls_line_model (
    input wire logic clk,
    input wire logic txLine,
    output logic rxLine
);
    initial rxLine = 1'b1;
    // caller supplies start, data, parity and stop, lsb first
    task automatic sendBits(input logic [11:0] b, input int n);
        @(posedge clk);
        for (int i = 0; i < n; i++) begin
            rxLine <= b[i];
            repeat (16) @(posedge clk);
        end
        rxLine <= 1'b1;
    endtask : sendBits
    // mid-bit sampling; unsent positions read as mark
    task automatic recvBits(input int n, output logic [11:0] b,
        output logic ok);
        int t;
        b = 12'hfff;
        t = 0;
        while (txLine !== 1'b0 && t < 2000) begin
            @(posedge clk);
            t++;
        end
        ok = (t < 2000);
        repeat (8) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            b[i] = txLine;
            repeat (16) @(posedge clk);
        end
    endtask : recvBits
endmodule : uls_line_model
`default_nettype wire

// [sim/test_uart_line_modem_control_status.sv]
/*
 bench for uls_top: register tasks, tx/rx frames, status and pins.
 assumes divisor 1 after reset and a one-cycle wishbone answer.
*/
`timescale 1ns/1ps
`default_nettype none
module test_uart_line_modem_control_status;
    logic clk, resetn, cyc, stb, we, ack, txSerial, irTx, dtrN, rtsN;
    logic interrupt_output_select_pin, busMode68, intOut, intOe, opOneN, opTwoN, rxLine, ok, irRx;
    logic [7:0] adr, r;
    logic [31:0] wdat, rdat;
    logic [11:0] bits;
    int errors, tests_run;
    uls_top uls_top_inst (.clk(clk), .resetn(resetn), .ce(1'b1),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'h1),
        .dat_i(wdat), .ack_o(ack), .dat_o(rdat), .rxSerial(rxLine),
        .txSerial(txSerial), .irRx(irRx), .irTx(irTx), .dtrN(dtrN),
        .rtsN(rtsN), .interruptOutputSelectPin(interrupt_output_select_pin),
        .busMode68(busMode68), .intOut(intOut), .intOe(intOe),
        .internalOutputOneN(opOneN), .internalOutputTwoN(opTwoN));
    uls_line_model uls_line_model_inst (.clk(clk), .txLine(txSerial),
        .rxLine(rxLine));
    initial clk = 1'b0;
    always #2 clk = ~clk;
    function automatic logic [11:0] frame(input logic [7:0] d,
        input logic [7:0] line_format_control);
        int len;
        logic [11:0] f;
        len = 5 + int'(line_format_control[1:0]);
        f = 12'hffe;
        for (int i = 0; i < len; i++) f[i + 1] = d[i];
        if (line_format_control[3])
            f[len + 1] = line_format_control[5] ? ~line_format_control[4]
                : ~line_format_control[4] ^ (^(d & (8'hff >> (8 - len))));
        return f;
    endfunction : frame
    task complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    task chk(input string nm, input logic [15:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task wb(input logic [7:0] a, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 24'h000000, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        r = rdat[7:0];
        {cyc, stb} <= 2'b00;
        if (n >= 50) begin
            errors++;
            complete_run();
        end
        @(posedge clk);
    endtask : wb
    task testReset;
        chk("pins", {txSerial, irTx, dtrN, rtsN, intOut}, 5'h16);
        wb(8'h0c, 1'b0, 8'h00);
        chk("lcr", r, 8'h00);
        wb(8'h10, 1'b0, 8'h00);
        chk("mcr", r, 8'h00);
        wb(8'h14, 1'b0, 8'h00);
        chk("lsr", r, 8'h20);
        wb(8'he0, 1'b0, 8'h00);
        chk("unmapped", r, 8'h00);
        $display("done reset");
    endtask : testReset
    task testModem;
        wb(8'h10, 1'b1, 8'h03);
        chk("dtr rts", {dtrN, rtsN}, 2'h0);
        wb(8'h10, 1'b1, 8'h08);
        chk("int on", intOe, 1'b1);
        wb(8'h10, 1'b1, 8'h00);
        chk("int off", intOe, 1'b0);
        interrupt_output_select_pin <= 1'b1;
        @(posedge clk);
        chk("int sel", intOe, 1'b1);
        interrupt_output_select_pin <= 1'b0;
        busMode68 <= 1'b1;
        @(posedge clk);
        chk("mode68", intOe, 1'b1);
        busMode68 <= 1'b0;
        wb(8'h10, 1'b1, 8'h1c);
        chk("loop", {opOneN, opTwoN, dtrN, txSerial}, 4'h3);
        wb(8'h10, 1'b1, 8'h14);
        chk("loop op2", {opOneN, opTwoN}, 2'h1);
        wb(8'h10, 1'b1, 8'h00);
        chk("normal", {opOneN, opTwoN, dtrN}, 3'h7);
        $display("done modem");
    endtask : testModem
    task testTx;
        logic [7:0] lcrs [6] = '{8'h03, 8'h0b, 8'h1b, 8'h2b, 8'h3b, 8'h08};
        for (int k = 0; k < 6; k++) begin
            wb(8'h0c, 1'b1, lcrs[k]);
            fork
                uls_line_model_inst.recvBits(7 + lcrs[k][1:0] + lcrs[k][3],
                    bits, ok);
                wb(8'h00, 1'b1, 8'h35);
            join
            chk("tx", {ok, bits},
                {1'b1, frame(8'h35, lcrs[k])});
        end
        wb(8'h0c, 1'b1, 8'h43);
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            chk("break", txSerial, 1'b0);
        end
        wb(8'h0c, 1'b1, 8'h03);
        chk("unbreak", txSerial, 1'b1);
        wb(8'h00, 1'b1, 8'h55);
        wb(8'h00, 1'b1, 8'h55);
        wb(8'h14, 1'b0, 8'h00);
        chk("thr full", r[5], 1'b0);
        for (int i = 0; i < 100 && r[5] !== 1'b1; i++) begin
            wb(8'h14, 1'b0, 8'h00);
        end
        chk("thr empty", r[5], 1'b1);
        $display("done tx");
    endtask : testTx
    task testRx;
        wb(8'h0c, 1'b1, 8'h0b);
        wb(8'h04, 1'b1, 8'h04);
        uls_line_model_inst.sendBits(frame(8'ha5, 8'h0b), 11);
        wb(8'h14, 1'b0, 8'h00);
        chk("ready", r[2:0], 3'h1);
        wb(8'h00, 1'b0, 8'h00);
        chk("rx data", r, 8'ha5);
        wb(8'h14, 1'b0, 8'h00);
        chk("empty", r[0], 1'b0);
        uls_line_model_inst.sendBits(frame(8'h3c, 8'h0b) ^ 12'h200, 11);
        chk("pe int", intOut, 1'b1);
        wb(8'h14, 1'b0, 8'h00);
        chk("pe", r[3:0], 4'h5);
        chk("int clear", intOut, 1'b0);
        wb(8'h00, 1'b0, 8'h00);
        uls_line_model_inst.sendBits(frame(8'h3c, 8'h0b) ^ 12'h400, 11);
        wb(8'h14, 1'b0, 8'h00);
        chk("fe", r[3:0], 4'h9);
        wb(8'h00, 1'b0, 8'h00);
        uls_line_model_inst.sendBits(frame(8'h11, 8'h0b), 11);
        uls_line_model_inst.sendBits(frame(8'h22, 8'h0b), 11);
        chk("ovr int", intOut, 1'b1);
        wb(8'h14, 1'b0, 8'h00);
        chk("overrun", r[1:0], 2'h3);
        wb(8'h00, 1'b0, 8'h00);
        chk("kept", r, 8'h11);
        uls_line_model_inst.sendBits(12'h000, 12);
        wb(8'h14, 1'b0, 8'h00);
        chk("brk", {r[4], r[0]}, 2'h3);
        wb(8'h00, 1'b0, 8'h00);
        wb(8'h14, 1'b0, 8'h00);
        chk("one brk", r[0], 1'b0);
        $display("done rx");
    endtask : testRx
    task testDivisor;
        wb(8'h0c, 1'b1, 8'h83);
        wb(8'h00, 1'b1, 8'h07);
        wb(8'h00, 1'b0, 8'h00);
        chk("div lo", r, 8'h07);
        wb(8'h04, 1'b0, 8'h00);
        chk("div hi", r, 8'h00);
        wb(8'h00, 1'b1, 8'h01);
        wb(8'h0c, 1'b1, 8'h03);
        wb(8'h04, 1'b0, 8'h00);
        chk("ier", r, 8'h04);
        $display("done divisor");
    endtask : testDivisor
    task testIr;
        logic [11:0] f;
        int n;
        f = frame(8'h5a, 8'h03);
        n = 0;
        wb(8'h08, 1'b1, 8'h10);
        wb(8'h10, 1'b1, 8'h40);
        chk("ir idle", irTx, 1'b0);
        wb(8'h00, 1'b1, 8'h00);
        repeat (16) begin
            @(posedge clk);
            n += int'(irTx === 1'b1);
        end
        chk("ir pulse", 16'(n), uls_pkg::IR_PULSE_TICKS);
        for (int i = 0; i < 10; i++) begin
            irRx <= ~f[i];
            @(posedge clk);
            irRx <= 1'b0;
            repeat (15) @(posedge clk);
        end
        wb(8'h00, 1'b0, 8'h00);
        chk("ir rx", r, 8'h5a);
        wb(8'h10, 1'b1, 8'h80);
        wb(8'h00, 1'b1, 8'hff);
        n = 0;
        repeat (80) begin
            @(posedge clk);
            n += int'(txSerial === 1'b0);
        end
        chk("presc", 16'((n + 3) / 4), 16'(uls_pkg::BIT_TICKS));
        $display("done ir");
    endtask : testIr
    initial begin
        {resetn, cyc, stb, we, interrupt_output_select_pin, busMode68, irRx} = 7'h00;
        adr = 8'h00;
        wdat = 32'h00000000;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        testReset();
        testModem();
        testTx();
        testRx();
        testDivisor();
        testIr();
        complete_run();
    end
endmodule : test_uart_line_modem_control_status
`default_nettype wire
